/* File: verilog/plrs_pkg.sv */
/*
 * Sequencer package: register map, fields, reset values, timing, states.
 * Assumes a 200 MHz clock and classic 32-bit Wishbone.
 */
package plrs_pkg;

    // ************************************************************
    // Clock and time base
    // ************************************************************
    localparam int unsigned CLK_PERIOD_PS = 5000;
    localparam int unsigned TICK_PERIOD_MS = 100;
    localparam int unsigned TICK_CYCLES =
        (TICK_PERIOD_MS * 1000) / (CLK_PERIOD_PS / 1000) * 1000;

    // ************************************************************
    // Register offsets (byte addresses)
    // ************************************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_UV_ALLOW = 8'h04;
    localparam logic [7:0] OFS_RETRY_WAIT = 8'h08;
    localparam logic [7:0] OFS_FREQ_THR = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h18;

    // ************************************************************
    // Control register fields
    // ************************************************************
    localparam int MODE_LSB = 0;
    localparam int ALEN_LSB = 2;
    localparam int CNTSEL_BIT = 4;
    localparam int FUNC_LSB = 8;

    localparam logic [1:0] MODE_TRIP = 2'h0;
    localparam logic [1:0] MODE_ZERO = 2'h1;
    localparam logic [1:0] MODE_MATCH = 2'h2;
    localparam logic [1:0] MODE_MATCH_STOP = 2'h3;

    localparam logic [1:0] ALEN_OFF = 2'h0;
    localparam logic [1:0] ALEN_ON = 2'h1;
    localparam logic [1:0] ALEN_RUN_ONLY = 2'h2;

    localparam logic [7:0] FUNC_POWER_LOSS = 8'h08;

    // ************************************************************
    // Reset values (times in 0.1 s units, frequency in 0.01 Hz)
    // ************************************************************
    localparam logic [1:0] RST_MODE = 2'h0;
    localparam logic [1:0] RST_ALEN = 2'h1;
    localparam logic RST_CNTSEL = 1'b0;
    localparam logic [7:0] RST_FUNC = 8'h08;
    localparam logic [9:0] RST_UV_ALLOW = 10'h00A;
    localparam logic [9:0] RST_RETRY_WAIT = 10'h003;
    localparam logic [15:0] RST_FREQ_THR = 16'h0000;

    // ************************************************************
    // Limits
    // ************************************************************
    localparam logic [4:0] UV_RETRY_MAX = 5'd16;
    localparam logic [1:0] OC_RETRY_MAX = 2'd3;

    // ************************************************************
    // Interrupt status bits
    // ************************************************************
    localparam int IRQ_TRIP = 0;
    localparam int IRQ_RESTART = 1;
    localparam int IRQ_PLOSS = 2;
    localparam int IRQ_FAULT = 3;
    localparam int IRQ_W = 4;

    // ************************************************************
    // Sequencer states
    // ************************************************************
    typedef enum logic [5:0] {
        ST_RUN = 6'b00_0001,
        ST_OUTAGE = 6'b00_0010,
        ST_WAIT = 6'b00_0100,
        ST_RESTART = 6'b00_1000,
        ST_DECEL = 6'b01_0000,
        ST_TRIP = 6'b10_0000
    } plrs_state_e;

endpackage

/* File: verilog/plrs_tick.sv */
/*
 * Divider that turns the system clock into a one-cycle enable pulse.
 * Assumes a free running clock and a synchronous active high reset.
 */
`timescale 1ns/1ps
module plrs_tick #(
    parameter int unsigned CYCLES = 20
) (
    input wire logic clk_i,
    input wire logic rst_i,
    output logic tick_o
);
    logic [31:0] cnt;
    logic [31:0] next_cnt;
    logic next_tick;

    always_comb begin
        next_tick = 1'b0;
        next_cnt = cnt + 32'd1;
        if (cnt >= CYCLES - 1) begin
            next_cnt = 32'h0000_0000;
            next_tick = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt <= 32'h0000_0000;
            tick_o <= 1'b0;
        end else begin
            cnt <= next_cnt;
            tick_o <= next_tick;
        end
    end
endmodule

/* File: verilog/plrs_top.sv */
/*
 * Power-loss retry sequencer with Wishbone registers.
 * Assumes async fault pins and key; other inputs on clk_i.
 */
// Chosen here: the address map and register access over Wishbone.
//
// Contract
// - Mode 00: trip, never restart; alarm on supply faults follows alarm enable
// - Mode 01 restarts from zero; 02 frequency-matches
// - Mode 03: match, decelerate to stop, then trip
// - Power fault: up to 16 restarts, 17th trips
// - Exhausted-retry trip latched until stop/reset key
// - Over-current/voltage: three restarts, fourth fault trips
// - Under-voltage longer than allowance trips, else retry
// - Wait programmable delay before restarting motor
// - Alarm enable: off, on, off while stopping
// - Count select: 16 restarts or unlimited
// - Motor below threshold restarts from zero frequency
// - Function code 08 drives power-loss output
// - Power-loss output low while supply present
// - Match only when output frequency exceeds threshold
`timescale 1ns/1ps
module plrs_top
    import plrs_pkg::*;
#(
    parameter int unsigned TICK_LEN = TICK_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic power_fail_i,
    input wire logic undervolt_i,
    input wire logic overcurrent_i,
    input wire logic overvolt_i,
    input wire logic stop_reset_key_i,
    input wire logic [15:0] motor_freq_i,
    input wire logic [15:0] out_freq_i,
    input wire logic stopping_i,
    input wire logic motor_stopped_i,
    input wire logic run_ok_i,
    output logic alarm_o,
    output logic trip_o,
    output logic restart_o,
    output logic restart_match_o,
    output logic decel_o,
    output logic power_loss_flag_o,
    output logic undervolt_flag_o,
    output logic irq_o
);

    // ************************************************************
    // Input synchronisers and time base
    // ************************************************************
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic key_q;
    logic tick;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1 <= 5'h00;
            sync2 <= 5'h00;
            key_q <= 1'b0;
        end else begin
            sync1 <= {stop_reset_key_i, overvolt_i, overcurrent_i, undervolt_i, power_fail_i};
            sync2 <= sync1;
            key_q <= sync2[4];
        end
    end

    wire pf = sync2[0];
    wire uv = sync2[1];
    wire oc_ov = sync2[2] | sync2[3];
    wire key_press = sync2[4] & ~key_q;
    wire supply_fault = pf | uv;

    plrs_tick #(
        .CYCLES(TICK_LEN)
    ) u_tick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_o(tick)
    );

    // ************************************************************
    // Configuration registers
    // ************************************************************
    logic [1:0] restart_mode_sel;
    logic [1:0] powerfail_alarm_en;
    logic restart_count_sel;
    logic [7:0] out_func_sel;
    logic [9:0] undervolt_allow_time;
    logic [9:0] retry_wait_time;
    logic [15:0] restart_freq_threshold;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;

    // ************************************************************
    // Sequencer
    // ************************************************************
    plrs_state_e state;
    plrs_state_e next_state;
    logic [9:0] timer;
    logic [9:0] next_timer;
    logic [4:0] uv_cnt;
    logic [4:0] next_uv_cnt;
    logic [1:0] oc_cnt;
    logic [1:0] next_oc_cnt;
    logic next_alarm;
    logic next_restart;
    logic next_match;
    logic [IRQ_W-1:0] ev;
    logic next_ploss;

    wire alarm_for_supply = (powerfail_alarm_en == ALEN_ON) ||
        (powerfail_alarm_en == ALEN_RUN_ONLY && !stopping_i);
    // Frequency match needs both the motor and the drive above threshold
    wire match_ok = (restart_mode_sel != MODE_ZERO) &&
        (motor_freq_i > restart_freq_threshold) &&
        (out_freq_i > restart_freq_threshold);

    always_comb begin
        next_state = state;
        next_timer = timer;
        next_uv_cnt = uv_cnt;
        next_oc_cnt = oc_cnt;
        next_alarm = alarm_o;
        next_restart = 1'b0;
        next_match = restart_match_o;
        ev = '0;
        ev[IRQ_PLOSS] = next_ploss & ~power_loss_flag_o;
        case (state)
            ST_RUN: begin
                if (run_ok_i) begin
                    next_uv_cnt = 5'd0;
                    next_oc_cnt = 2'd0;
                end
                if (supply_fault) begin
                    ev[IRQ_FAULT] = 1'b1;
                    next_timer = 10'h000;
                    if (restart_mode_sel == MODE_TRIP) begin
                        next_state = ST_TRIP;
                        next_alarm = alarm_for_supply;
                        ev[IRQ_TRIP] = 1'b1;
                    end else begin
                        next_state = ST_OUTAGE;
                    end
                end else if (oc_ov) begin
                    ev[IRQ_FAULT] = 1'b1;
                    next_timer = 10'h000;
                    if (restart_mode_sel == MODE_TRIP || oc_cnt == OC_RETRY_MAX) begin
                        next_state = ST_TRIP;
                        next_alarm = 1'b1;
                        ev[IRQ_TRIP] = 1'b1;
                    end else begin
                        next_oc_cnt = oc_cnt + 2'd1;
                        next_state = ST_WAIT;
                    end
                end
            end
            ST_OUTAGE: begin
                if (supply_fault) begin
                    if (tick) begin
                        next_timer = timer + 10'd1;
                    end
                    // Trips regardless of mode once the allowance runs out
                    if (timer >= undervolt_allow_time) begin
                        next_state = ST_TRIP;
                        next_alarm = alarm_for_supply;
                        ev[IRQ_TRIP] = 1'b1;
                    end
                end else if (!restart_count_sel && uv_cnt == UV_RETRY_MAX) begin
                    next_state = ST_TRIP;
                    next_alarm = alarm_for_supply;
                    ev[IRQ_TRIP] = 1'b1;
                end else begin
                    if (!restart_count_sel) begin
                        next_uv_cnt = uv_cnt + 5'd1;
                    end
                    next_timer = 10'h000;
                    next_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (supply_fault) begin
                    next_timer = 10'h000;
                    next_state = ST_OUTAGE;
                end else if (timer >= retry_wait_time) begin
                    next_state = ST_RESTART;
                end else if (tick) begin
                    next_timer = timer + 10'd1;
                end
            end
            ST_RESTART: begin
                next_restart = 1'b1;
                next_match = match_ok;
                ev[IRQ_RESTART] = 1'b1;
                if (restart_mode_sel == MODE_MATCH_STOP) begin
                    next_state = ST_DECEL;
                end else begin
                    next_state = ST_RUN;
                end
            end
            ST_DECEL: begin
                if (motor_stopped_i) begin
                    next_state = ST_TRIP;
                    next_alarm = 1'b1;
                    ev[IRQ_TRIP] = 1'b1;
                end
            end
            ST_TRIP: begin
                // Only the operator key leaves the trip; software cannot
                if (key_press) begin
                    next_state = ST_RUN;
                    next_alarm = 1'b0;
                    next_uv_cnt = 5'd0;
                    next_oc_cnt = 2'd0;
                end
            end
            default: begin
                next_state = ST_TRIP;
                next_alarm = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_RUN;
            timer <= 10'h000;
            uv_cnt <= 5'd0;
            oc_cnt <= 2'd0;
            alarm_o <= 1'b0;
            restart_o <= 1'b0;
            restart_match_o <= 1'b0;
        end else begin
            state <= next_state;
            timer <= next_timer;
            uv_cnt <= next_uv_cnt;
            oc_cnt <= next_oc_cnt;
            alarm_o <= next_alarm;
            restart_o <= next_restart;
            restart_match_o <= next_match;
        end
    end

    // ************************************************************
    // Status outputs
    // ************************************************************
    assign next_ploss = (out_func_sel == FUNC_POWER_LOSS) && pf;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            power_loss_flag_o <= 1'b0;
            undervolt_flag_o <= 1'b0;
            trip_o <= 1'b0;
            decel_o <= 1'b0;
        end else begin
            power_loss_flag_o <= next_ploss;
            undervolt_flag_o <= uv;
            trip_o <= (next_state == ST_TRIP);
            decel_o <= (next_state == ST_DECEL);
        end
    end

    // ************************************************************
    // Wishbone slave and interrupts
    // ************************************************************
    logic next_ack;
    logic [31:0] next_dat;
    logic [1:0] next_mode;
    logic [1:0] next_alen;
    logic next_cntsel;
    logic [7:0] next_func;
    logic [9:0] next_allow;
    logic [9:0] next_wait;
    logic [15:0] next_thr;
    logic [IRQ_W-1:0] next_istat;
    logic [IRQ_W-1:0] next_imask;
    logic wr;

    always_comb begin
        next_ack = wb_cyc_i & wb_stb_i & ~wb_ack_o;
        wr = next_ack & wb_we_i;
        next_dat = 32'h0000_0000;
        next_mode = restart_mode_sel;
        next_alen = powerfail_alarm_en;
        next_cntsel = restart_count_sel;
        next_func = out_func_sel;
        next_allow = undervolt_allow_time;
        next_wait = retry_wait_time;
        next_thr = restart_freq_threshold;
        next_imask = irq_mask;
        next_istat = irq_stat;
        case (wb_adr_i)
            OFS_CTRL: begin
                next_dat[MODE_LSB +: 2] = restart_mode_sel;
                next_dat[ALEN_LSB +: 2] = powerfail_alarm_en;
                next_dat[CNTSEL_BIT] = restart_count_sel;
                next_dat[FUNC_LSB +: 8] = out_func_sel;
                if (wr && wb_sel_i[0]) begin
                    next_mode = wb_dat_i[MODE_LSB +: 2];
                    next_alen = wb_dat_i[ALEN_LSB +: 2];
                    next_cntsel = wb_dat_i[CNTSEL_BIT];
                end
                if (wr && wb_sel_i[1]) begin
                    next_func = wb_dat_i[FUNC_LSB +: 8];
                end
            end
            OFS_UV_ALLOW: begin
                next_dat[9:0] = undervolt_allow_time;
                if (wr && wb_sel_i[0] && wb_sel_i[1]) begin
                    next_allow = wb_dat_i[9:0];
                end
            end
            OFS_RETRY_WAIT: begin
                next_dat[9:0] = retry_wait_time;
                if (wr && wb_sel_i[0] && wb_sel_i[1]) begin
                    next_wait = wb_dat_i[9:0];
                end
            end
            OFS_FREQ_THR: begin
                next_dat[15:0] = restart_freq_threshold;
                if (wr && wb_sel_i[0] && wb_sel_i[1]) begin
                    next_thr = wb_dat_i[15:0];
                end
            end
            OFS_STATUS: begin
                next_dat[5:0] = state;
                next_dat[12:8] = uv_cnt;
                next_dat[17:16] = oc_cnt;
            end
            OFS_IRQ_STAT: begin
                next_dat[IRQ_W-1:0] = irq_stat;
                if (wr && wb_sel_i[0]) begin
                    next_istat = irq_stat & ~wb_dat_i[IRQ_W-1:0];
                end
            end
            OFS_IRQ_MASK: begin
                next_dat[IRQ_W-1:0] = irq_mask;
                if (wr && wb_sel_i[0]) begin
                    next_imask = wb_dat_i[IRQ_W-1:0];
                end
            end
            default: begin
                next_dat = 32'h0000_0000;
            end
        endcase
        // A new event in the clearing cycle wins over the clear
        next_istat = next_istat | ev;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            restart_mode_sel <= RST_MODE;
            powerfail_alarm_en <= RST_ALEN;
            restart_count_sel <= RST_CNTSEL;
            out_func_sel <= RST_FUNC;
            undervolt_allow_time <= RST_UV_ALLOW;
            retry_wait_time <= RST_RETRY_WAIT;
            restart_freq_threshold <= RST_FREQ_THR;
            irq_stat <= '0;
            irq_mask <= '0;
            irq_o <= 1'b0;
        end else begin
            wb_ack_o <= next_ack;
            wb_dat_o <= next_dat;
            restart_mode_sel <= next_mode;
            powerfail_alarm_en <= next_alen;
            restart_count_sel <= next_cntsel;
            out_func_sel <= next_func;
            undervolt_allow_time <= next_allow;
            retry_wait_time <= next_wait;
            restart_freq_threshold <= next_thr;
            irq_stat <= next_istat;
            irq_mask <= next_imask;
            irq_o <= |(next_istat & next_imask);
        end
    end

endmodule

/* File: dv/plrs_motor_model.sv */
/*
 * Motor and drive model for the sequencer.
 * Assumes the bench sets the speed; shares clk_i.
 */
`timescale 1ns/1ps
module plrs_motor_model #(
    parameter int STOP_DLY = 5
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic restart_i,
    input wire logic decel_i,
    input wire logic ok_en_i,
    input wire logic [15:0] freq_i,
    output logic [15:0] motor_freq_o,
    output logic [15:0] out_freq_o,
    output logic stopped_o,
    output logic run_ok_o
);
    logic [3:0] dcnt;
    logic [2:0] okd;
    // Run-ok only when the bench allows it, so retry counts can build up
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            motor_freq_o <= 16'h0000;
            out_freq_o <= 16'h0000;
            stopped_o <= 1'b0;
            run_ok_o <= 1'b0;
            dcnt <= 4'h0;
            okd <= 3'h0;
        end else begin
            motor_freq_o <= freq_i;
            out_freq_o <= freq_i;
            dcnt <= decel_i ? dcnt + {3'h0, dcnt != 4'hF} : 4'h0;
            stopped_o <= decel_i && (dcnt >= 4'(STOP_DLY));
            okd <= {okd[1:0], restart_i && ok_en_i};
            run_ok_o <= okd[2];
        end
    end
endmodule

/* File: dv/plrs_top_sva.sv */
/*
 * Concurrent checks on the sequencer's ports.
 * Assumes it is bound into plrs_top.
 */
`timescale 1ns/1ps
module plrs_top_sva (
    input logic clk_i,
    input logic rst_i,
    input logic wb_cyc_i,
    input logic wb_stb_i,
    input logic wb_ack_o,
    input logic power_fail_i,
    input logic stop_reset_key_i,
    input logic [15:0] motor_freq_i,
    input logic [15:0] out_freq_i,
    input logic alarm_o,
    input logic trip_o,
    input logic restart_o,
    input logic restart_match_o,
    input logic decel_o,
    input logic power_loss_flag_o
);
    // Pin history covers the synchroniser latency
    logic [7:0] key_h;
    logic [7:0] pf_h;
    always_ff @(posedge clk_i) begin
        key_h <= {key_h[6:0], stop_reset_key_i};
        pf_h <= {pf_h[6:0], power_fail_i};
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    ack_time_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    restart_pulse_a: assert property (restart_o |=> !restart_o)
        else $error("restart pulse too long");
    no_restart_trip_a: assert property (restart_o |-> !trip_o && !alarm_o)
        else $error("restart while tripped");
    trip_hold_a: assert property ($fell(trip_o) |-> |key_h)
        else $error("trip cleared without key");
    alarm_trip_a: assert property (alarm_o |-> trip_o || $past(trip_o))
        else $error("alarm without trip");
    decel_end_a: assert property ($fell(decel_o) |-> ##[0:1] trip_o)
        else $error("decel not ended in trip");
    ploss_low_a: assert property (power_loss_flag_o |-> |pf_h)
        else $error("power loss flag with supply present");
    match_freq_a: assert property (restart_o && restart_match_o |->
        motor_freq_i != 16'h0000 && out_freq_i != 16'h0000)
        else $error("match restart at zero speed");
endmodule
bind plrs_top plrs_top_sva u_sva (.*);

/* File: dv/test_power_loss_retry_sequencer.sv */
/*
 * Self-checking bench for the power-loss retry sequencer.
 * Assumes a shortened tick (TICK_LEN 4) and the motor model beside it.
 */
`timescale 1ns/1ps
module test_power_loss_retry_sequencer
    import plrs_pkg::*;
;
    localparam int TK = 4;
    logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, key = 0, stp = 0, ok_en = 1;
    logic [7:0] adr = 0;
    logic [31:0] wdat = 0, rdat, rq;
    logic [3:0] flt = 0;
    logic [15:0] fset = 0, mf, of;
    logic ack, stopped, run_ok, alarm, trip, rs, match, decel, plf, irq;
    wire logic [3:0] ev;
    int n_errors = 0, n_checks = 0, n;
    assign ev = {decel, alarm, trip, rs};
    always #2.5 clk_i = ~clk_i;
    plrs_top #(.TICK_LEN(TK)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .power_fail_i(flt[0]), .undervolt_i(flt[1]),
        .overcurrent_i(flt[2]), .overvolt_i(flt[3]), .stop_reset_key_i(key),
        .motor_freq_i(mf), .out_freq_i(of), .stopping_i(stp), .motor_stopped_i(stopped),
        .run_ok_i(run_ok), .alarm_o(alarm), .trip_o(trip), .restart_o(rs),
        .restart_match_o(match), .decel_o(decel), .power_loss_flag_o(plf),
        .undervolt_flag_o(), .irq_o(irq));
    plrs_motor_model #(.STOP_DLY(5)) u_motor (.clk_i(clk_i), .rst_i(rst_i),
        .restart_i(rs), .decel_i(decel), .ok_en_i(ok_en), .freq_i(fset),
        .motor_freq_o(mf), .out_freq_o(of), .stopped_o(stopped), .run_ok_o(run_ok));
    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    // Request held until ack is seen; data taken at that same edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        i = 0;
        do begin
            @(posedge clk_i);
            i++;
        end while (ack !== 1'b1 && i < 50);
        rq = rdat;
        cyc <= 1'b0;
        we <= 1'b0;
        if (i >= 50) n_errors++;
    endtask
    task automatic cfg(input logic [1:0] md, input logic [1:0] al, input logic cs);
        wb(1'b1, OFS_CTRL, {16'h0000, FUNC_POWER_LOSS, 3'h0, cs, al, md});
    endtask
    task automatic hold(input int b, input int c);
        @(posedge clk_i) flt[b] <= 1'b1;
        repeat (c) @(posedge clk_i);
        flt[b] <= 1'b0;
    endtask
    task automatic wait_ev(input int b, input int lim, output int k);
        k = 0;
        while (ev[b] !== 1'b1 && k < lim) begin
            @(posedge clk_i);
            k++;
        end
    endtask
    task automatic clr();
        @(posedge clk_i) key <= 1'b1;
        repeat (6) @(posedge clk_i);
        key <= 1'b0;
        repeat (6) @(posedge clk_i);
        chk(trip, 0, "trip after key");
    endtask
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_regs();
        wb(0, OFS_CTRL, 0);
        chk(rq, 32'h0000_0804, "ctrl reset");
        wb(0, OFS_UV_ALLOW, 0);
        chk(rq, 32'h0000_000A, "allow reset");
        wb(0, OFS_RETRY_WAIT, 0);
        chk(rq, 32'h0000_0003, "wait reset");
        wb(1, 8'hFC, 32'hFFFF_FFFF);
        wb(0, 8'hFC, 0);
        chk(rq, 32'h0000_0000, "unmapped");
        $display("test regs done");
    endtask
    task automatic t_mode0();
        cfg(MODE_TRIP, ALEN_ON, 0);
        wb(1, OFS_IRQ_MASK, 32'h0000_000F);
        @(posedge clk_i) flt[0] <= 1'b1;
        wait_ev(1, 20, n);
        repeat (3) @(posedge clk_i);
        chk(alarm, 1, "mode0 alarm");
        chk(plf, 1, "loss flag");
        chk(irq, 1, "irq raised");
        flt[0] <= 1'b0;
        repeat (40) @(posedge clk_i);
        chk(trip, 1, "no restart");
        chk(plf, 0, "loss flag low");
        wb(1, OFS_IRQ_MASK, 0);
        repeat (2) @(posedge clk_i);
        chk(irq, 0, "irq masked");
        wb(1, OFS_IRQ_MASK, 32'h0000_000F);
        wb(1, OFS_IRQ_STAT, 32'h0000_000F);
        repeat (2) @(posedge clk_i);
        chk(irq, 0, "irq cleared");
        clr();
        $display("test mode0 done");
    endtask
    task automatic t_rs(input logic [1:0] md, input logic [15:0] thr, input logic [15:0] f,
            input logic em);
        cfg(md, ALEN_ON, 0);
        wb(1, OFS_FREQ_THR, {16'h0000, thr});
        fset <= f;
        hold(0, 6);
        wait_ev(0, 60, n);
        chk(n > 2 * TK && n <= 3 * TK + 12, 1, "retry wait");
        chk(match, em, "match kind");
        repeat (10) @(posedge clk_i);
        $display("test restart mode %0d done", md);
    endtask
    task automatic t_m3();
        cfg(MODE_MATCH_STOP, ALEN_ON, 0);
        fset <= 16'h07D0;
        hold(0, 6);
        wait_ev(0, 60, n);
        chk(match, 1, "mode3 match");
        wait_ev(3, 20, n);
        chk(decel, 1, "mode3 decel");
        wait_ev(1, 40, n);
        chk(alarm, 1, "mode3 trip");
        clr();
        $display("test mode3 done");
    endtask
    task automatic t_uv(input logic [1:0] al, input logic s, input logic ea);
        cfg(MODE_ZERO, al, 0);
        stp <= s;
        @(posedge clk_i) flt[1] <= 1'b1;
        wait_ev(1, 10 * TK + 20, n);
        chk(n > 9 * TK && n < 10 * TK + 20, 1, "uv allowance");
        repeat (2) @(posedge clk_i);
        chk(alarm, ea, "alarm enable");
        flt[1] <= 1'b0;
        stp <= 1'b0;
        clr();
        $display("test undervolt done");
    endtask
    task automatic t_cnt(input logic cs);
        int r;
        ok_en <= 1'b0;
        cfg(MODE_ZERO, ALEN_ON, cs);
        r = 0;
        for (int i = 0; i < 17; i++) begin
            hold(0, 6);
            wait_ev(0, 60, n);
            if (n < 60) r++;
        end
        chk(r, cs ? 17 : 16, "restart count");
        chk(trip, !cs, "17th trips");
        if (!cs) clr();
        hold(0, 6);
        wait_ev(0, 60, n);
        chk(n < 60, 1, "count reset");
        $display("test count done");
    endtask
    task automatic t_oc();
        int r;
        cfg(MODE_ZERO, ALEN_ON, 0);
        r = 0;
        for (int i = 0; i < 4; i++) begin
            hold(2 + i % 2, 4);
            wait_ev(0, 60, n);
            if (n < 60) r++;
        end
        chk(r, 3, "oc retries");
        chk(trip, 1, "oc trip");
        chk(alarm, 1, "oc alarm");
        clr();
        $display("test overcurrent done");
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        conclude();
    end
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_mode0();
        t_rs(MODE_ZERO, 16'h03E8, 16'h07D0, 0);
        t_rs(MODE_MATCH, 16'h03E8, 16'h07D0, 1);
        t_rs(MODE_MATCH, 16'h03E8, 16'h01F4, 0);
        t_m3();
        t_uv(ALEN_OFF, 0, 0);
        t_uv(ALEN_ON, 0, 1);
        t_uv(ALEN_RUN_ONLY, 1, 0);
        t_uv(ALEN_RUN_ONLY, 0, 1);
        t_cnt(0);
        t_cnt(1);
        t_oc();
        conclude();
    end
endmodule
